/* File: verilog/dcr_regs.sv */
// Purpose: DPLL configuration register bank behind an AHB-Lite slave
// Assumes: Loop controller and tuning word logic share hclk
// Notes:   Zero wait states; reads answer in the data phase from a flop
`timescale 1ns/10ps
module dcr_regs (
  // Clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   ce,
  // AHB-Lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic                   hready,
  input  wire logic [31:0]            hwdata,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // Loop controller status
  input  wire dcr_pkg::dcr_mode_e     loop_mode,
  input  wire logic                   ref_switch,
  input  wire logic                   history_valid,
  input  wire logic [47:0]            loop_word,
  // Tuning word processing
  output logic      [47:0]            proc_word,
  output logic      [47:0]            holdover_word,
  output logic      [47:0]            clamped_word,
  output logic                        clamp_active,
  output logic                        history_clear,
  output logic                        slew_limit_en,
  output dcr_pkg::dcr_cfg_s           cfg
);
  logic [47:0]                  frw;
  logic [23:0]                  lower;
  logic [23:0]                  upper;
  logic [15:0]                  olpo;
  logic [39:0]                  fixed_ofs;
  logic [15:0]                  step_ps;
  logic [15:0]                  slew_ns;
  logic [23:0]                  hist_ms;
  logic [7:0]                   hctrl;
  logic [dcr_pkg::NUM_REGS*8-1:0] rbytes;
  logic                         wr_pend;
  logic [9:0]                   wr_idx;
  logic                         wr_go;
  logic                         commit;
  logic                         addr_hit;
  logic [9:0]                   rd_idx;
  logic [9:0]                   rd_off;
  logic [7:0]                   rd_byte;
  dcr_pkg::dcr_mode_e           prev_mode;
  logic                         hold_entry;
  logic                         fallback;
  logic                         persist;

  // Address phase: only NONSEQ to the decoded window is a transfer
  assign rd_idx   = haddr[dcr_pkg::ADDR_TOP-1:dcr_pkg::ADDR_LSB];
  assign addr_hit = hsel && hready && htrans == dcr_pkg::HTRANS_NSEQ;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx  <= '0;
    end else if (ce && hready) begin
      wr_pend <= addr_hit && hwrite && haddr[31:dcr_pkg::ADDR_TOP] == '0;
      wr_idx  <= rd_idx;
    end
  end

  assign wr_go  = wr_pend && ce;
  assign commit = wr_go && wr_idx == dcr_pkg::IDX_COMMIT
                  && hwdata[dcr_pkg::BIT_COMMIT];

  // Storage: one field module per documented register group
  dcr_field #(.NB(dcr_pkg::NB_FRW), .BASE(dcr_pkg::IDX_FRW),
              .RST(dcr_pkg::RST_FRW), .MASK(dcr_pkg::MASK_FULL)) u_frw (
    .clk(hclk), .rst_n(hresetn), .ce(ce), .wr_en(wr_go), .wr_idx(wr_idx),
    .wr_byte(hwdata[7:0]), .value(frw));
  dcr_field #(.NB(dcr_pkg::NB_LIM), .BASE(dcr_pkg::IDX_LOWER),
              .RST(dcr_pkg::RST_LOWER), .MASK(dcr_pkg::MASK_FULL)) u_lower (
    .clk(hclk), .rst_n(hresetn), .ce(ce), .wr_en(wr_go), .wr_idx(wr_idx),
    .wr_byte(hwdata[7:0]), .value(lower));
  dcr_field #(.NB(dcr_pkg::NB_LIM), .BASE(dcr_pkg::IDX_UPPER),
              .RST(dcr_pkg::RST_UPPER), .MASK(dcr_pkg::MASK_FULL)) u_upper (
    .clk(hclk), .rst_n(hresetn), .ce(ce), .wr_en(wr_go), .wr_idx(wr_idx),
    .wr_byte(hwdata[7:0]), .value(upper));
  dcr_field #(.NB(dcr_pkg::NB_OLPO), .BASE(dcr_pkg::IDX_OLPO),
              .RST(dcr_pkg::RST_OLPO), .MASK(dcr_pkg::MASK_FULL)) u_olpo (
    .clk(hclk), .rst_n(hresetn), .ce(ce), .wr_en(wr_go), .wr_idx(wr_idx),
    .wr_byte(hwdata[7:0]), .value(olpo));
  dcr_field #(.NB(dcr_pkg::NB_FIXED), .BASE(dcr_pkg::IDX_FIXED),
              .RST(dcr_pkg::RST_FIXED), .MASK(dcr_pkg::MASK_FULL)) u_fixed (
    .clk(hclk), .rst_n(hresetn), .ce(ce), .wr_en(wr_go), .wr_idx(wr_idx),
    .wr_byte(hwdata[7:0]), .value(fixed_ofs));
  dcr_field #(.NB(dcr_pkg::NB_STEP), .BASE(dcr_pkg::IDX_STEP),
              .RST(dcr_pkg::RST_STEP), .MASK(dcr_pkg::MASK_FULL)) u_step (
    .clk(hclk), .rst_n(hresetn), .ce(ce), .wr_en(wr_go), .wr_idx(wr_idx),
    .wr_byte(hwdata[7:0]), .value(step_ps));
  dcr_field #(.NB(dcr_pkg::NB_SLEW), .BASE(dcr_pkg::IDX_SLEW),
              .RST(dcr_pkg::RST_SLEW), .MASK(dcr_pkg::MASK_FULL)) u_slew (
    .clk(hclk), .rst_n(hresetn), .ce(ce), .wr_en(wr_go), .wr_idx(wr_idx),
    .wr_byte(hwdata[7:0]), .value(slew_ns));
  dcr_field #(.NB(dcr_pkg::NB_HIST), .BASE(dcr_pkg::IDX_HIST),
              .RST(dcr_pkg::RST_HIST), .MASK(dcr_pkg::MASK_FULL)) u_hist (
    .clk(hclk), .rst_n(hresetn), .ce(ce), .wr_en(wr_go), .wr_idx(wr_idx),
    .wr_byte(hwdata[7:0]), .value(hist_ms));
  dcr_field #(.NB(dcr_pkg::NB_HCTRL), .BASE(dcr_pkg::IDX_HCTRL),
              .RST(dcr_pkg::RST_HCTRL), .MASK(dcr_pkg::MASK_HCTRL)) u_hctrl (
    .clk(hclk), .rst_n(hresetn), .ce(ce), .wr_en(wr_go), .wr_idx(wr_idx),
    .wr_byte(hwdata[7:0]), .value(hctrl));

  assign fallback = hctrl[dcr_pkg::BIT_FALLBK];
  assign persist  = hctrl[dcr_pkg::BIT_PERSIST];

  // Flat byte image in index order; commit slot always reads zero
  assign rbytes = {hctrl, hist_ms, slew_ns, step_ps, fixed_ofs, olpo,
                   upper, lower, 8'h00, frw};

  // Read mux
  always_comb begin
    rd_off  = rd_idx - dcr_pkg::IDX_FRW;
    rd_byte = 8'h00;
    if (haddr[31:dcr_pkg::ADDR_TOP] == '0 && rd_idx >= dcr_pkg::IDX_FRW
        && rd_idx <= dcr_pkg::IDX_HCTRL) begin
      rd_byte = rbytes[rd_off*8 +: 8];
    end
  end

  // Read data captured at the address phase edge; unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && addr_hit && !hwrite) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

  // Ready from the first enabled edge after reset; never errors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= dcr_pkg::HRESP_OKAY;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp     <= dcr_pkg::HRESP_OKAY;
    end
  end

  // Processing register: follows free-run word in free-run, else on commit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      proc_word <= dcr_pkg::RST_FRW;
    end else if (ce && (loop_mode == dcr_pkg::MODE_FREE || commit)) begin
      proc_word <= frw;
    end
  end

  // Holdover entry detect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_mode <= dcr_pkg::MODE_FREE;
    end else if (ce) begin
      prev_mode <= loop_mode;
    end
  end

  assign hold_entry = loop_mode == dcr_pkg::MODE_HOLD
                      && prev_mode != dcr_pkg::MODE_HOLD;

  // With history the averaging logic owns the holdover word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      holdover_word <= dcr_pkg::RST_FRW;
    end else if (ce && hold_entry && !history_valid) begin
      holdover_word <= fallback ? loop_word : frw;
    end
  end

  // History wipe on reference switch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      history_clear <= 1'b0;
    end else if (ce) begin
      history_clear <= ref_switch && !persist;
    end
  end

  // Limits compare against the top 24 bits of the 48-bit word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clamped_word <= '0;
      clamp_active <= 1'b0;
    end else if (ce) begin
      if (loop_word[47:24] < lower) begin
        clamped_word <= {lower, 24'h00_0000};
        clamp_active <= 1'b1;
      end else if (loop_word[47:24] > upper) begin
        clamped_word <= {upper, 24'hFF_FFFF};
        clamp_active <= 1'b1;
      end else begin
        clamped_word <= loop_word;
        clamp_active <= 1'b0;
      end
    end
  end

  // Slew limiter enable registered so the output stays a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slew_limit_en <= 1'b0;
    end else if (ce) begin
      slew_limit_en <= slew_ns != dcr_pkg::RST_SLEW;
    end
  end

  assign cfg = '{olpo: olpo, fixed_ofs: fixed_ofs, step_ps: step_ps,
                 slew_ns: slew_ns, hist_ms: hist_ms,
                 avg_mode: hctrl[dcr_pkg::AVG_LSB +: dcr_pkg::AVG_W]};

  // Checks
  sequence s_commit_addr;
    ce && hready && hsel && htrans == dcr_pkg::HTRANS_NSEQ && hwrite
    && haddr == {20'h00000, dcr_pkg::IDX_COMMIT, 2'h0};
  endsequence

  sequence s_commit_data;
    ce && hwdata[dcr_pkg::BIT_COMMIT];
  endsequence

  a_commit_copy: assert property (@(posedge hclk) disable iff (!hresetn)
    s_commit_addr ##1 s_commit_data |=> proc_word == $past(frw))
    else $error("commit did not copy free-run word");

  a_commit_reads_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && addr_hit && !hwrite && haddr == {20'h00000, dcr_pkg::IDX_COMMIT, 2'h0})
    |=> hrdata == 32'h0000_0000)
    else $error("commit register read nonzero");

  a_freerun_track: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && loop_mode == dcr_pkg::MODE_FREE) |=> proc_word == $past(frw))
    else $error("free-run word not applied");

  a_reset_values: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> lower == 24'h000000 && upper == 24'hFFFFFF
    && step_ps == 16'h03E8 && hist_ms == 24'h007530 && frw == '0)
    else $error("wrong reset defaults");

  a_slew_disable: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && slew_ns == 16'h0000) |=> !slew_limit_en)
    else $error("slew limit active at zero rate");

  a_hold_fallback: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && hold_entry && !history_valid)
    |=> holdover_word == ($past(fallback) ? $past(loop_word) : $past(frw)))
    else $error("wrong holdover word");

  a_hist_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    ce |=> history_clear == ($past(ref_switch) && !$past(persist)))
    else $error("history clear mismatch");

  a_avg_range: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_go && wr_idx == dcr_pkg::IDX_HCTRL
    |=> hctrl == (8'($past(hwdata)) & dcr_pkg::MASK_HCTRL)
    && cfg.avg_mode == 3'($past(hwdata)))
    else $error("history mode field wrong");

  a_clamp_bounds: assert property (@(posedge hclk) disable iff (!hresetn)
    ce ##1 ce |-> clamped_word[47:24] >= $past(lower)
    || $past(lower) > $past(upper) || clamp_active == 1'b0)
    else $error("clamped word below lower limit");

  a_clamp_high: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && loop_word[47:24] > upper && loop_word[47:24] >= lower)
    |=> clamp_active && clamped_word == {$past(upper), 24'hFF_FFFF})
    else $error("upper clamp not applied");

  // Storage, read path, output hold and output value checks
  sequence s_frw_read;
    ce && addr_hit && !hwrite
    && haddr == {20'h00000, dcr_pkg::IDX_FRW, 2'h0};
  endsequence

  a_frw_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_go && wr_idx == dcr_pkg::IDX_FRW)
    |=> frw[7:0] == 8'($past(hwdata)))
    else $error("free-run low byte write lost");

  a_frw_read: assert property (@(posedge hclk) disable iff (!hresetn)
    s_frw_read
    |=> hrdata == {24'h00_0000, 8'($past(frw))})
    else $error("free-run low byte read wrong");

  a_lower_top: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_go && wr_idx == dcr_pkg::IDX_LOWER + 10'h002)
    |=> lower[23:16] == 8'($past(hwdata)))
    else $error("lower limit top byte write lost");

  a_proc_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && loop_mode != dcr_pkg::MODE_FREE && !commit)
    |=> $stable(proc_word))
    else $error("processing word moved without commit");

  a_hold_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !(hold_entry && !history_valid))
    |=> $stable(holdover_word))
    else $error("holdover word moved outside entry");

  a_hist_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !ref_switch)
    |=> !history_clear)
    else $error("history clear without reference switch");

  a_slew_enable: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && slew_ns != dcr_pkg::RST_SLEW)
    |=> slew_limit_en)
    else $error("slew limit off at nonzero rate");

  a_clamp_pass: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && loop_word[47:24] >= lower && loop_word[47:24] <= upper)
    |=> !clamp_active && clamped_word == $past(loop_word))
    else $error("in-range word altered");

  a_clamp_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && loop_word[47:24] < lower)
    |=> clamp_active && clamped_word == {$past(lower), 24'h00_0000})
    else $error("lower clamp not applied");
endmodule

/* File: verilog/dcr_pkg.sv */
// Purpose: Constants and types for the DPLL configuration register bank
// Assumes: Register index times four is the AHB byte address
// Notes:   One byte register per 32-bit word, data in bits [7:0]
package dcr_pkg;
  // Register indices (byte address = index * 4)
  localparam logic [9:0]  IDX_FRW     = 10'h300;
  localparam logic [9:0]  IDX_COMMIT  = 10'h306;
  localparam logic [9:0]  IDX_LOWER   = 10'h307;
  localparam logic [9:0]  IDX_UPPER   = 10'h30A;
  localparam logic [9:0]  IDX_OLPO    = 10'h30D;
  localparam logic [9:0]  IDX_FIXED   = 10'h30F;
  localparam logic [9:0]  IDX_STEP    = 10'h314;
  localparam logic [9:0]  IDX_SLEW    = 10'h316;
  localparam logic [9:0]  IDX_HIST    = 10'h318;
  localparam logic [9:0]  IDX_HCTRL   = 10'h31B;
  localparam int          NUM_REGS    = 28;
  localparam int          IDX_W       = 10;
  localparam int          ADDR_LSB    = 2;
  localparam int          ADDR_TOP    = 12;
  // Field byte counts
  localparam int          NB_FRW      = 6;
  localparam int          NB_LIM      = 3;
  localparam int          NB_OLPO     = 2;
  localparam int          NB_FIXED    = 5;
  localparam int          NB_STEP     = 2;
  localparam int          NB_SLEW     = 2;
  localparam int          NB_HIST     = 3;
  localparam int          NB_HCTRL    = 1;
  // Reset values and write masks
  localparam logic [47:0] RST_FRW     = 48'h0000_0000_0000;
  localparam logic [23:0] RST_LOWER   = 24'h000000;
  localparam logic [23:0] RST_UPPER   = 24'hFFFFFF;
  localparam logic [15:0] RST_OLPO    = 16'h0000;
  localparam logic [39:0] RST_FIXED   = 40'h00_0000_0000;
  localparam logic [15:0] RST_STEP    = 16'h03E8;
  localparam logic [15:0] RST_SLEW    = 16'h0000;
  localparam logic [23:0] RST_HIST    = 24'h007530;
  localparam logic [7:0]  RST_HCTRL   = 8'h00;
  localparam logic [7:0]  MASK_HCTRL  = 8'h1F;
  localparam logic [7:0]  MASK_FULL   = 8'hFF;
  // Bit positions, field widths and bus encodings
  localparam int          BIT_COMMIT  = 0;
  localparam int          BIT_FALLBK  = 4;
  localparam int          BIT_PERSIST = 3;
  localparam int          AVG_LSB     = 0;
  localparam int          AVG_W       = 3;
  localparam int          FTW_W       = 48;
  localparam int          LIM_W       = 24;
  localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
  localparam logic        HRESP_OKAY  = 1'h0;

  // Loop state reported by the loop controller, Gray along free->closed->hold
  typedef enum logic [1:0] {
    MODE_FREE   = 2'h0,
    MODE_CLOSED = 2'h1,
    MODE_HOLD   = 2'h3
  } dcr_mode_e;

  typedef struct packed {
    logic [15:0]      olpo;
    logic [39:0]      fixed_ofs;
    logic [15:0]      step_ps;
    logic [15:0]      slew_ns;
    logic [23:0]      hist_ms;
    logic [AVG_W-1:0] avg_mode;
  } dcr_cfg_s;
endpackage

/* File: verilog/dcr_field.sv */
// Purpose: Multi-byte register with per-byte write at consecutive indices
// Assumes: One byte written per access
// Notes:   Bits cleared in MASK read and hold zero
`timescale 1ns/10ps
module dcr_field #(
  parameter int             NB   = 1,
  parameter logic [9:0]     BASE = 10'h000,
  parameter logic [NB*8-1:0] RST = '0,
  parameter logic [7:0]     MASK = 8'hFF
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            ce,
  // Write port
  input  wire logic            wr_en,
  input  wire logic [9:0]      wr_idx,
  input  wire logic [7:0]      wr_byte,
  // Stored value
  output logic      [NB*8-1:0] value
);
  if (NB < 1 || NB > 8) begin : g_bad_nb
    $error("dcr_field: NB must be 1 to 8");
  end

  for (genvar i = 0; i < NB; i++) begin : g_byte
    localparam logic [9:0] MY_IDX = BASE + 10'(i);
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        value[i*8 +: 8] <= RST[i*8 +: 8];
      end else if (ce && wr_en && wr_idx == MY_IDX) begin
        value[i*8 +: 8] <= wr_byte & MASK;
      end
    end
  end
endmodule

/* File: bench/tb_dpll_config_registers.sv */
// Purpose: Self-checking bench for the DPLL configuration register bank
// Assumes: Zero wait states; outputs are registered, so negedge values equal sampled values
// Notes:   A byte image of all 28 registers predicts every read and every configuration output
`timescale 1ns/10ps
module tb_dpll_config_registers;
  logic                hclk;
  logic                hresetn;
  logic                ce;
  logic                hsel;
  logic [31:0]         haddr;
  logic [1:0]          htrans;
  logic                hwrite;
  logic [2:0]          hsize;
  logic [31:0]         hwdata;
  logic [31:0]         hrdata;
  logic                hreadyout;
  logic                hresp;
  dcr_pkg::dcr_mode_e  loop_mode;
  logic                ref_switch;
  logic                history_valid;
  logic [47:0]         loop_word;
  logic [47:0]         proc_word;
  logic [47:0]         holdover_word;
  logic [47:0]         clamped_word;
  logic                clamp_active;
  logic                history_clear;
  logic                slew_limit_en;
  dcr_pkg::dcr_cfg_s   cfg;
  logic [223:0]        mdl;
  logic [31:0]         rd;
  logic [47:0]         w;
  logic [47:0]         ex;
  logic [23:0]         lo;
  logic [23:0]         hi;
  int                  n_errors;
  int                  checks;
  int                  cyc;
  int                  seed_v;

  dcr_regs u_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .loop_mode(loop_mode), .ref_switch(ref_switch),
    .history_valid(history_valid), .loop_word(loop_word), .proc_word(proc_word),
    .holdover_word(holdover_word), .clamped_word(clamped_word), .clamp_active(clamp_active),
    .history_clear(history_clear), .slew_limit_en(slew_limit_en), .cfg(cfg)
  );

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic end_sim;
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles needed
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_sim;
    end
  end

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Registered outputs: the negedge value is what the next rising edge samples
  task automatic wait_rdy;
    @(negedge hclk);
    while (hreadyout !== 1'b1) begin
      @(negedge hclk);
    end
  endtask

  task automatic ahb(input logic [31:0] a, input logic wr, input logic [7:0] d);
    logic [31:0] r;
    r = $urandom();
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= dcr_pkg::HTRANS_NSEQ;
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_rdy;
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {r[31:8], d};
    wait_rdy;
    rd = hrdata;
    chk("hresp", hresp, dcr_pkg::HRESP_OKAY);
    @(posedge hclk);
  endtask

  function automatic logic [31:0] adr(input int i);
    return {20'h00000, dcr_pkg::IDX_FRW + 10'(i), 2'h0};
  endfunction

  task automatic bwr(input int i, input logic [7:0] d);
    ahb(adr(i), 1'b1, d);
    if (i == 27) mdl[i*8 +: 8] = d & dcr_pkg::MASK_HCTRL;
    else if (i != 6) mdl[i*8 +: 8] = d;
  endtask

  task automatic read_all;
    for (int i = 0; i < 28; i++) begin
      ahb(adr(i), 1'b0, 8'h00);
      chk("reg byte", rd, (i == 6) ? 32'h0 : {24'h0, mdl[i*8 +: 8]});
    end
    chk("olpo", cfg.olpo, mdl[119:104]);
    chk("fixed", cfg.fixed_ofs, mdl[159:120]);
    chk("step", cfg.step_ps, mdl[175:160]);
    chk("slew", cfg.slew_ns, mdl[191:176]);
    chk("slew en", slew_limit_en, mdl[191:176] != 16'h0);
    chk("hist", cfg.hist_ms, mdl[215:192]);
    chk("avg", cfg.avg_mode, mdl[218:216]);
  endtask

  function automatic logic [48:0] clamp_of(input logic [47:0] v);
    if (v[47:24] < mdl[79:56]) return {1'b1, mdl[79:56], 24'h000000};
    if (v[47:24] > mdl[103:80]) return {1'b1, mdl[103:80], 24'hFFFFFF};
    return {1'b0, v};
  endfunction

  task automatic step_cycles(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask

  initial begin
    {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    {ref_switch, history_valid, loop_word, n_errors, checks, cyc} = '0;
    hresetn   = 1'b0;
    ce        = 1'b1;
    loop_mode = dcr_pkg::MODE_CLOSED;
    mdl = {dcr_pkg::RST_HCTRL, dcr_pkg::RST_HIST, dcr_pkg::RST_SLEW, dcr_pkg::RST_STEP,
           dcr_pkg::RST_FIXED, dcr_pkg::RST_OLPO, dcr_pkg::RST_UPPER, dcr_pkg::RST_LOWER,
           8'h00, dcr_pkg::RST_FRW};
    seed_v = $urandom(88);
    repeat (5) @(posedge hclk);
    @(negedge hclk);
    chk("ready in reset", hreadyout, 1'b0);
    chk("step in reset", cfg.step_ps, dcr_pkg::RST_STEP);
    @(posedge hclk);
    hresetn <= 1'b1;
    read_all;
    chk("proc rst", proc_word, 48'h0);
    // Unmapped places read zero and swallow writes
    ahb(adr(28), 1'b1, 8'h5A);
    ahb(adr(28), 1'b0, 8'h00);
    chk("unmapped", rd, 32'h0);
    ahb(32'h0000_1000 | adr(0), 1'b0, 8'h00);
    chk("alias", rd, 32'h0);
    for (int i = 0; i < 28; i++) begin
      w[7:0] = $urandom();
      if (i == 6) w[7:0] = 8'h00;
      if (i == 24) w[7:0] = w[7:0] | 8'h01;
      bwr(i, w[7:0]);
    end
    read_all;
    bwr(23, 8'h00);
    bwr(22, 8'h00);
    step_cycles(1);
    chk("slew off", slew_limit_en, 1'b0);
    // Frozen clock enable takes no write
    @(posedge hclk);
    ce <= 1'b0;
    ahb(adr(0), 1'b1, ~mdl[7:0]);
    ce <= 1'b1;
    ahb(adr(0), 1'b0, 8'h00);
    chk("ce low", rd, {24'h0, mdl[7:0]});
    chk("no commit", proc_word, 48'h0);
    bwr(6, 8'h01);
    @(negedge hclk);
    chk("commit", proc_word, mdl[47:0]);
    ahb(adr(6), 1'b0, 8'h00);
    chk("commit clr", rd, 32'h0);
    ex = mdl[47:0];
    bwr(0, ~mdl[7:0]);
    step_cycles(2);
    chk("proc hold", proc_word, ex);
    @(posedge hclk);
    loop_mode <= dcr_pkg::MODE_FREE;
    bwr(5, ~mdl[47:40]);
    step_cycles(2);
    chk("free run", proc_word, mdl[47:0]);
    // Holdover entry: fallback bit picks the source, history present keeps the word
    for (int k = 0; k < 3; k++) begin
      bwr(27, (k == 1) ? 8'h10 : 8'h00);
      ex = holdover_word;
      w = {$urandom(), 16'(  $urandom())};
      loop_mode     <= dcr_pkg::MODE_CLOSED;
      loop_word     <= w;
      history_valid <= (k == 2);
      step_cycles(2);
      @(posedge hclk);
      loop_mode <= dcr_pkg::MODE_HOLD;
      step_cycles(2);
      chk("holdover", holdover_word, (k == 2) ? ex : (k == 1) ? w : mdl[47:0]);
    end
    @(posedge hclk);
    loop_mode <= dcr_pkg::MODE_CLOSED;
    for (int p = 0; p < 2; p++) begin
      bwr(27, p[0] ? 8'h08 : 8'h00);
      ref_switch <= 1'b1;
      @(posedge hclk);
      ref_switch <= 1'b0;
      @(negedge hclk);
      chk("hist clr", history_clear, !p[0]);
      @(negedge hclk);
      chk("hist clr end", history_clear, 1'b0);
    end
    lo = 24'h100000 | 24'($urandom() & 32'hFFFFF);
    hi = 24'hA00000 | 24'($urandom() & 32'hFFFFF);
    for (int i = 0; i < 3; i++) begin
      bwr(7 + i, lo[i*8 +: 8]);
      bwr(10 + i, hi[i*8 +: 8]);
    end
    for (int k = 0; k < 5; k++) begin
      w = {$urandom(), 16'($urandom())};
      case (k)
        0: w[47:24] = lo - 24'h1;
        1: w[47:24] = lo;
        2: w[47:24] = hi;
        3: w[47:24] = hi + 24'h1;
        default: w[47:24] = lo + 24'h1;
      endcase
      @(posedge hclk);
      loop_word <= w;
      step_cycles(2);
      ex = clamp_of(w);
      chk("clamped", clamped_word, ex);
      chk("clamp flag", clamp_active, clamp_of(w) >> 48);
    end
    end_sim;
  end
endmodule
